// ==== rtl/caime_exec.sv ====
// What this block does
// RULE1 - stack as destination: old first entry moves to second, loop flags pushed
// RULE2 - stack as source: second entry moves to first, loop flags popped
// RULE3 - full accumulator with extension in use saturates a 16-bit destination
// RULE4 - single accumulator words as source are never saturated
// RULE5 - limit flag stays set until the status word is loaded
// RULE6 - full accumulator destination: sign-extend, upper word, low word zero
// RULE7 - upper word destination writes that word only
// RULE8 - changed pointer, stack pointer, modulo reach addressing two instructions later
// RULE9 - software waits one instruction after changing stack pointer before push or pop
// RULE10 - offset write by a control move used by next instruction stretches one instruction cycle
// RULE11 - offset changed by bit-field reaches addressing two instructions later, no stretch
// RULE12 - software keeps stack or status moves off the last three loop addresses
// RULE13 - software places no stack move directly before a loop start
// RULE14 - software places no stack or status move directly before loop exit
// RULE15 - software places no status, stack, stack pointer move before returns
// RULE16 - software never moves stack to stack
// RULE17 - status word destination loads the eight flags from source bits 7..0
// RULE18 - otherwise only the limit flag may change, on saturation
// RULE19 - control move cycles and words follow the addressing mode
// RULE20 - register to register control move: 2 cycles, 1 word
// RULE21 - short immediate is sign-extended from bit 6
// RULE22 - short immediate to accumulator: extension sign, low word cleared, 2 cycles
// RULE23 - long immediate 4 cycles to register, 6 to memory; loop counter 13 bits
// RULE24 - immediate moves leave condition flags untouched
`timescale 1ns/1ps
`default_nettype none
module caime_exec
  import caime_pkg::*;
#(
  parameter int unsigned XMEM_DEPTH = 64,
  parameter int unsigned XMEM_AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic [4:0] op_src,
  input wire logic [4:0] op_dst,
  input wire logic [2:0] op_mode,
  input wire logic [1:0] op_ptr,
  input wire logic [15:0] op_ext,
  input wire logic [15:0] op_imm,
  input wire logic op_next_uses_n,
  input wire logic [4:0] rd_sel,
  output logic op_ready_q,
  output logic op_done_q,
  output logic [3:0] op_cycles_q,
  output logic [1:0] op_words_q,
  output logic [15:0] status_word_q,
  output logic nested_loop_q,
  output logic [35:0] acc_a_q,
  output logic [35:0] acc_b_q,
  output logic [15:0] sp_ptr_q,
  output logic [15:0] rd_data_q
);

  typedef struct packed {
    caime_state_e st;
    logic [3:0] cnt;
    logic ready;
    logic done;
    logic [3:0] cycles;
    logic [1:0] words;
    logic [1:0] kind;
    logic [4:0] src;
    logic [4:0] dst;
    logic [15:0] ea;
    logic [15:0] imm;
    logic [15:0] x0;
    logic [15:0] y0;
    logic [15:0] y1;
    logic [35:0] acca;
    logic [35:0] accb;
    logic [3:0][15:0] rr;
    logic [15:0] n;
    logic [15:0] sp;
    logic [15:0] m01;
    logic [12:0] lc;
    logic [15:0] hws0;
    logic [15:0] hws1;
    logic lf;
    logic nl;
    logic [1:0] imask;
    logic [7:0] condition_code_byte;
    logic [6:0][15:0] view;
    logic pend_v;
    logic [2:0] pend_i;
    logic [15:0] pend_val;
    logic [15:0] rd;
  } caime_state_s;

  caime_state_s s_q;
  caime_state_s s_d;
  logic [15:0] mem_rdata;
  logic mem_rd_en;
  logic mem_wr_en;
  logic [15:0] ea_now;
  logic [3:0] ncyc;
  logic [1:0] nwrd;
  logic commit;
  logic a_ovf;
  logic b_ovf;
  logic sat_ev;
  logic [15:0] src_v;
  logic [15:0] wv;
  logic is_ptr;
  logic [2:0] ptr_i;

  function automatic logic [15:0] raw16(input caime_state_s s, input logic [4:0] sel,
                                        input logic [15:0] mrd);
    logic [15:0] v;
    v = 16'h0000;
    case (sel)
      RG_X0: v = s.x0;
      RG_Y0: v = s.y0;
      RG_Y1: v = s.y1;
      RG_A, RG_A1: v = s.acca[31:16];
      RG_A0: v = s.acca[15:0];
      RG_B, RG_B1: v = s.accb[31:16];
      RG_B0: v = s.accb[15:0];
      RG_R0: v = s.rr[0];
      RG_R1: v = s.rr[1];
      RG_R2: v = s.rr[2];
      RG_R3: v = s.rr[3];
      RG_N: v = s.n;
      RG_SP: v = s.sp;
      RG_M01: v = s.m01;
      RG_SR: v = {s.lf, 5'h00, s.imask, s.condition_code_byte};
      RG_LC: v = {3'h0, s.lc};
      RG_HWS: v = s.hws0;
      RG_MEM: v = mrd;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // address, cost and value of the operation
  always_comb begin
    case (op_mode)
      MODE_IND: ea_now = s_q.view[op_ptr];
      MODE_ABS: ea_now = op_ext;
      MODE_IDXN: ea_now = s_q.view[op_ptr] + s_q.view[PV_N];
      MODE_DISP: ea_now = s_q.view[op_ptr] + op_ext;
      default: ea_now = 16'h0000;
    endcase
    ncyc = CYC_REG; // see RULE20
    nwrd = WRD_1;
    if (op_kind == KIND_IMM7) begin
      ncyc = CYC_IMM7; // see RULE22
    end else if (op_kind == KIND_IMM16) begin
      ncyc = (op_dst == RG_MEM) ? CYC_IMM16_MEM : CYC_IMM16_REG; // see RULE23
      nwrd = (op_dst == RG_MEM && op_mode == MODE_ABS) ? WRD_3 : WRD_2;
    end else if (op_kind == KIND_CTRL) begin
      case (op_mode) // see RULE19
        MODE_IND: ncyc = CYC_IND;
        MODE_ABS: begin
          ncyc = CYC_ABS;
          nwrd = WRD_2;
        end
        MODE_IDXN: ncyc = CYC_IDXN;
        MODE_DISP: begin
          ncyc = CYC_DISP;
          nwrd = WRD_2;
        end
        default: ncyc = CYC_REG;
      endcase
      if (op_dst == RG_N && op_next_uses_n) begin
        ncyc = 4'(ncyc + CYC_STRETCH); // see RULE10
      end
    end
    a_ovf = s_q.acca[35:31] != {5{s_q.acca[35]}};
    b_ovf = s_q.accb[35:31] != {5{s_q.accb[35]}};
    src_v = raw16(s_q, s_q.src, mem_rdata);
    // words of an accumulator bypass the limiter
    sat_ev = (s_q.kind == KIND_CTRL) &&
             ((s_q.src == RG_A && a_ovf) || (s_q.src == RG_B && b_ovf)); // see RULE3 RULE4
    case (s_q.kind)
      KIND_IMM7: wv = {{9{s_q.imm[6]}}, s_q.imm[6:0]}; // see RULE21
      KIND_CTRL: begin
        if (sat_ev) begin
          wv = ((s_q.src == RG_A) ? s_q.acca[35] : s_q.accb[35]) ? SAT_NEG : SAT_POS;
        end else begin
          wv = src_v;
        end
      end
      default: wv = s_q.imm;
    endcase
    is_ptr = (s_q.dst >= RG_R0) && (s_q.dst <= RG_M01);
    ptr_i = 3'(s_q.dst - RG_R0);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing and write-back
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rd = raw16(s_q, rd_sel, mem_rdata);
    mem_rd_en = 1'b0;
    mem_wr_en = 1'b0;
    commit = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (op_valid) begin
          s_d.st = ST_EXEC;
          s_d.cnt = ncyc;
          s_d.cycles = ncyc;
          s_d.words = nwrd;
          s_d.ready = 1'b0;
          s_d.kind = op_kind;
          s_d.src = op_src;
          s_d.dst = op_dst;
          s_d.ea = ea_now;
          s_d.imm = op_imm;
          mem_rd_en = (op_src == RG_MEM);
        end
      end
      ST_EXEC: begin
        s_d.cnt = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) begin
          commit = 1'b1;
          s_d.st = ST_IDLE;
          s_d.ready = 1'b1;
          s_d.done = 1'b1;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (commit) begin
      // the previous instruction's pointer write lands now
      if (s_q.pend_v) begin
        s_d.view[s_q.pend_i] = s_q.pend_val; // see RULE8 RULE11
      end
      s_d.pend_v = 1'b0;
      if (s_q.kind == KIND_CTRL && s_q.src == RG_HWS) begin
        s_d.hws0 = s_q.hws1; // see RULE2
        s_d.lf = s_q.nl;
        s_d.nl = 1'b0;
      end
      case (s_q.dst)
        RG_X0: s_d.x0 = wv;
        RG_Y0: s_d.y0 = wv;
        RG_Y1: s_d.y1 = wv;
        RG_A: s_d.acca = {{4{wv[15]}}, wv, 16'h0000}; // see RULE6 RULE22
        RG_B: s_d.accb = {{4{wv[15]}}, wv, 16'h0000}; // see RULE6 RULE22
        RG_A0: s_d.acca[15:0] = wv;
        RG_A1: s_d.acca[31:16] = wv; // see RULE7
        RG_B0: s_d.accb[15:0] = wv;
        RG_B1: s_d.accb[31:16] = wv; // see RULE7
        RG_R0: s_d.rr[0] = wv;
        RG_R1: s_d.rr[1] = wv;
        RG_R2: s_d.rr[2] = wv;
        RG_R3: s_d.rr[3] = wv;
        RG_N: s_d.n = wv;
        RG_SP: s_d.sp = wv; // see RULE9
        RG_M01: s_d.m01 = wv;
        RG_SR: begin
          s_d.lf = wv[15];
          s_d.imask = wv[9:8];
          s_d.condition_code_byte = wv[7:0]; // see RULE17
        end
        RG_LC: s_d.lc = wv[12:0]; // see RULE23
        RG_HWS: begin
          s_d.hws1 = s_q.hws0; // see RULE1
          s_d.hws0 = wv;
          s_d.nl = s_q.lf;
          s_d.lf = 1'b1;
        end
        RG_MEM: mem_wr_en = 1'b1;
        default: s_d.x0 = s_q.x0;
      endcase
      // only a status load may drop the sticky limit flag
      if (sat_ev && s_q.dst != RG_SR) begin
        s_d.condition_code_byte[SRB_L] = 1'b1; // see RULE5 RULE18
      end
      if (is_ptr) begin
        if (s_q.kind == KIND_CTRL && s_q.dst == RG_N) begin
          s_d.view[PV_N] = wv; // see RULE10
        end else begin
          s_d.pend_v = 1'b1; // see RULE8 RULE11
          s_d.pend_i = ptr_i;
          s_d.pend_val = wv;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.ready <= 1'b1;
      s_q.imask <= RST_IMASK;
      s_q.condition_code_byte <= RST_CCR;
    end else begin
      s_q <= s_d;
    end
  end

  caime_xmem #(
    .DEPTH(XMEM_DEPTH),
    .AW(XMEM_AW)
  ) u_xmem (
    .clk(clk),
    .rst_n(rst_n),
    .rd_en(mem_rd_en),
    .rd_addr(ea_now[XMEM_AW-1:0]),
    .wr_en(mem_wr_en),
    .wr_addr(s_q.ea[XMEM_AW-1:0]),
    .wr_data(wv),
    .rd_data_q(mem_rdata)
  );

  assign op_ready_q = s_q.ready;
  assign op_done_q = s_q.done;
  assign op_cycles_q = s_q.cycles;
  assign op_words_q = s_q.words;
  assign status_word_q = {s_q.lf, 5'h00, s_q.imask, s_q.condition_code_byte};
  assign nested_loop_q = s_q.nl;
  assign acc_a_q = s_q.acca;
  assign acc_b_q = s_q.accb;
  assign sp_ptr_q = s_q.view[PV_SP];
  assign rd_data_q = s_q.rd;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_hws_push_copy: assert property ( // see RULE1
    commit && s_q.dst == RG_HWS && s_q.src != RG_HWS |=>
      s_q.hws1 == $past(s_q.hws0) && s_q.lf && s_q.nl == $past(s_q.lf))
    else $error("stack push did not shift entries");
  chk_hws_pop_copy: assert property ( // see RULE2
    commit && s_q.kind == KIND_CTRL && s_q.src == RG_HWS && s_q.dst != RG_SR &&
    s_q.dst != RG_HWS |=> s_q.hws0 == $past(s_q.hws1) && s_q.lf == $past(s_q.nl))
    else $error("stack pop did not shift entries");
  chk_acc_limit_neg: assert property ( // see RULE3
    commit && s_q.kind == KIND_CTRL && s_q.src == RG_A && a_ovf && s_q.acca[35] &&
    s_q.dst == RG_Y0 |=> s_q.y0 == SAT_NEG && s_q.condition_code_byte[SRB_L])
    else $error("negative limit missing");
  chk_word_no_limit: assert property ( // see RULE4
    commit && s_q.src == RG_A1 && s_q.dst == RG_Y1 |=> s_q.y1 == $past(src_v))
    else $error("accumulator word was limited");
  chk_limit_sticky: assert property ( // see RULE5
    s_q.condition_code_byte[SRB_L] && !(commit && s_q.dst == RG_SR) |=> s_q.condition_code_byte[SRB_L])
    else $error("limit flag dropped");
  chk_acc_sign_ext: assert property ( // see RULE6
    commit && s_q.dst == RG_A |=> s_q.acca[31:16] == $past(wv) &&
      s_q.acca[15:0] == 16'h0000 && s_q.acca[35:32] == {4{s_q.acca[31]}})
    else $error("accumulator load not extended");
  chk_upper_only: assert property ( // see RULE7
    commit && s_q.dst == RG_A1 |=> $stable(s_q.acca[15:0]) && $stable(s_q.acca[35:32]))
    else $error("upper word write touched other parts");
  chk_ptr_view_delay: assert property ( // see RULE8
    commit && is_ptr && !(s_q.kind == KIND_CTRL && s_q.dst == RG_N) && !s_q.pend_v |=>
      $stable(s_q.view) && s_q.pend_v)
    else $error("pointer reached address path too early");
  chk_n_stretch: assert property ( // see RULE10
    s_q.st == ST_IDLE && op_valid && op_kind == KIND_CTRL && op_dst == RG_N &&
    op_mode == MODE_REG && op_next_uses_n |=> s_q.cycles == 4'h4 ##4 s_q.done)
    else $error("offset write not stretched");
  chk_sr_load: assert property ( // see RULE17
    commit && s_q.dst == RG_SR |=> status_word_q == ($past(wv) & SR_MASK))
    else $error("status word load wrong");
  chk_imm_no_flags: assert property ( // see RULE24
    commit && s_q.kind != KIND_CTRL && s_q.dst != RG_SR |=> $stable(s_q.condition_code_byte))
    else $error("immediate move changed flags");
  chk_imm7_ext: assert property ( // see RULE21
    commit && s_q.kind == KIND_IMM7 && s_q.dst == RG_X0 |=> s_q.x0[15:7] == {9{s_q.x0[6]}})
    else $error("short immediate not sign extended");

endmodule
`default_nettype wire

// ==== rtl/caime_pkg.sv ====
package caime_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // operation kinds
  localparam logic [1:0] KIND_CTRL = 2'h0;
  localparam logic [1:0] KIND_IMM7 = 2'h1;
  localparam logic [1:0] KIND_IMM16 = 2'h2;
  localparam logic [1:0] KIND_BITF = 2'h3;

  // addressing modes of the memory operand
  localparam logic [2:0] MODE_REG = 3'h0;
  localparam logic [2:0] MODE_IND = 3'h1;
  localparam logic [2:0] MODE_ABS = 3'h2;
  localparam logic [2:0] MODE_IDXN = 3'h3;
  localparam logic [2:0] MODE_DISP = 3'h4;

  ////////////////////////////////////////////////////////////////////////////////
  // register codes for source and destination
  localparam logic [4:0] RG_X0 = 5'h00;
  localparam logic [4:0] RG_Y0 = 5'h01;
  localparam logic [4:0] RG_Y1 = 5'h02;
  localparam logic [4:0] RG_A = 5'h03;
  localparam logic [4:0] RG_B = 5'h04;
  localparam logic [4:0] RG_A0 = 5'h05;
  localparam logic [4:0] RG_A1 = 5'h06;
  localparam logic [4:0] RG_B0 = 5'h07;
  localparam logic [4:0] RG_B1 = 5'h08;
  localparam logic [4:0] RG_R0 = 5'h09;
  localparam logic [4:0] RG_R1 = 5'h0A;
  localparam logic [4:0] RG_R2 = 5'h0B;
  localparam logic [4:0] RG_R3 = 5'h0C;
  localparam logic [4:0] RG_N = 5'h0D;
  localparam logic [4:0] RG_SP = 5'h0E;
  localparam logic [4:0] RG_M01 = 5'h0F;
  localparam logic [4:0] RG_SR = 5'h10;
  localparam logic [4:0] RG_LC = 5'h11;
  localparam logic [4:0] RG_HWS = 5'h12;
  localparam logic [4:0] RG_MEM = 5'h13;

  // pointer path slots
  localparam logic [2:0] PV_N = 3'h4;
  localparam logic [2:0] PV_SP = 3'h5;
  localparam logic [2:0] PV_M01 = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // clock cycles and program words per form
  localparam logic [3:0] CYC_REG = 4'h2;
  localparam logic [3:0] CYC_IND = 4'h2;
  localparam logic [3:0] CYC_ABS = 4'h4;
  localparam logic [3:0] CYC_IDXN = 4'h4;
  localparam logic [3:0] CYC_DISP = 4'h6;
  localparam logic [3:0] CYC_IMM7 = 4'h2;
  localparam logic [3:0] CYC_IMM16_REG = 4'h4;
  localparam logic [3:0] CYC_IMM16_MEM = 4'h6;
  localparam logic [3:0] CYC_STRETCH = 4'h2;
  localparam logic [1:0] WRD_1 = 2'h1;
  localparam logic [1:0] WRD_2 = 2'h2;
  localparam logic [1:0] WRD_3 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // status word layout, limits, reset values
  localparam int unsigned SRB_L = 6;
  localparam logic [15:0] SR_MASK = 16'h83FF;
  localparam logic [15:0] SAT_POS = 16'h7FFF;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [1:0] RST_IMASK = 2'h3;
  localparam logic [7:0] RST_CCR = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } caime_state_e;

endpackage

// ==== rtl/caime_xmem.sv ====
`timescale 1ns/1ps
`default_nettype none
module caime_xmem #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data_q
);

  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0] rd;
  } caime_xmem_s;

  caime_xmem_s m_q;
  caime_xmem_s m_d;

  ////////////////////////////////////////////////////////////////////////////////
  // read data held until the next read
  always_comb begin
    m_d = m_q;
    if (wr_en) begin
      m_d.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      m_d.rd = m_q.mem[rd_addr];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= '0;
    end else begin
      m_q <= m_d;
    end
  end

  assign rd_data_q = m_q.rd;

endmodule
`default_nettype wire

// ==== tb/caime_exec_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module caime_exec_test;
  import caime_pkg::*;
  logic clk, rst_n, op_valid, op_next_uses_n;
  logic [1:0] op_kind, op_ptr;
  logic [4:0] op_src, op_dst, rd_sel;
  logic [2:0] op_mode;
  logic [15:0] op_ext, op_imm;
  logic op_ready_q, op_done_q, nested_loop_q;
  logic [3:0] op_cycles_q;
  logic [1:0] op_words_q;
  logic [15:0] status_word_q, sp_ptr_q, rd_data_q;
  logic [35:0] acc_a_q, acc_b_q;
  int failures, total_checks;

  caime_exec DUT (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_kind(op_kind),
    .op_src(op_src), .op_dst(op_dst), .op_mode(op_mode), .op_ptr(op_ptr),
    .op_ext(op_ext), .op_imm(op_imm), .op_next_uses_n(op_next_uses_n),
    .rd_sel(rd_sel), .op_ready_q(op_ready_q), .op_done_q(op_done_q),
    .op_cycles_q(op_cycles_q), .op_words_q(op_words_q),
    .status_word_q(status_word_q), .nested_loop_q(nested_loop_q),
    .acc_a_q(acc_a_q), .acc_b_q(acc_b_q), .sp_ptr_q(sp_ptr_q),
    .rd_data_q(rd_data_q));

  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one op, held until accepted; done counted edge by edge
  task automatic op(input logic [1:0] k, input logic [4:0] s, input logic [4:0] d,
      input logic [2:0] m, input logic [1:0] p, input logic [15:0] e,
      input logic [15:0] i, input logic nx, input logic [3:0] ec, input logic [1:0] ew);
    int n;
    n = 0;
    while (op_ready_q !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    op_kind = k;
    op_src = s;
    op_dst = d;
    op_mode = m;
    op_ptr = p;
    op_ext = e;
    op_imm = i;
    op_next_uses_n = nx;
    op_valid = 1'b1;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
    n = 0;
    while (op_done_q !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("cycles seen", 36'(n), 36'(ec));
    chk("cycles out", 36'(op_cycles_q), 36'(ec));
    chk("words out", 36'(op_words_q), 36'(ew));
  endtask

  task automatic mv(input logic [4:0] s, input logic [4:0] d);
    op(KIND_CTRL, s, d, MODE_REG, 2'h0, 16'h0000, 16'h0000, 1'b0, 4'h2, 2'h1);
  endtask

  task automatic im(input logic [4:0] d, input logic [15:0] val);
    op(KIND_IMM16, 5'h00, d, MODE_REG, 2'h0, 16'h0000, val, 1'b0, 4'h4, 2'h2);
  endtask

  task automatic mw(input logic [15:0] a, input logic [15:0] val);
    op(KIND_IMM16, 5'h00, RG_MEM, MODE_ABS, 2'h0, a, val, 1'b0, 4'h6, 2'h3);
  endtask

  task automatic rc(input string nm, input logic [4:0] s, input logic [15:0] exp);
    rd_sel = s;
    @(posedge clk);
    #1;
    chk(nm, 36'(rd_data_q), 36'(exp));
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("status rst", 36'(status_word_q), 36'h0300);
    chk("ready rst", 36'(op_ready_q), 36'h1);
    chk("nl rst", 36'(nested_loop_q), 36'h0);
  endtask

  task automatic t_imm;
    op(KIND_IMM7, 5'h00, RG_X0, MODE_REG, 2'h0, 16'h0, 16'h0047, 1'b0, 4'h2, 2'h1);
    rc("x0 imm7", RG_X0, 16'hFFC7);
    op(KIND_IMM7, 5'h00, RG_A, MODE_REG, 2'h0, 16'h0, 16'h003F, 1'b0, 4'h2, 2'h1);
    chk("a imm7", acc_a_q, 36'h0_003F_0000);
    im(RG_B0, 16'h1234);
    op(KIND_IMM7, 5'h00, RG_B, MODE_REG, 2'h0, 16'h0, 16'h0047, 1'b0, 4'h2, 2'h1);
    chk("b imm7", acc_b_q, 36'hF_FFC7_0000);
    mw(16'h0010, 16'hAAAA);
    op(KIND_IMM16, 5'h00, RG_MEM, MODE_DISP, 2'h0, 16'h0, 16'hBBBB, 1'b0, 4'h6, 2'h2);
    im(RG_LC, 16'h1FFF);
    rc("lc", RG_LC, 16'h1FFF);
    chk("status imm", 36'(status_word_q), 36'h0300);
  endtask

  task automatic t_acc;
    im(RG_X0, 16'h8001);
    mv(RG_X0, RG_A);
    chk("a full", acc_a_q, 36'hF_8001_0000);
    im(RG_A0, 16'h1234);
    im(RG_X0, 16'h5555);
    mv(RG_X0, RG_A1);
    chk("a upper", acc_a_q, 36'hF_5555_1234);
    mv(RG_A, RG_Y0);
    rc("sat neg", RG_Y0, 16'h8000);
    chk("limit set", 36'(status_word_q), 36'h0340);
    mv(RG_A1, RG_Y1);
    rc("no sat", RG_Y1, 16'h5555);
    mv(RG_X0, RG_Y0);
    chk("limit sticky", 36'(status_word_q), 36'h0340);
    im(RG_X0, 16'h0001);
    mv(RG_X0, RG_B);
    im(RG_X0, 16'h9000);
    mv(RG_X0, RG_B1);
    op(KIND_CTRL, RG_B, RG_MEM, MODE_ABS, 2'h0, 16'h0020, 16'h0, 1'b0, 4'h4, 2'h2);
    op(KIND_CTRL, RG_MEM, RG_Y1, MODE_ABS, 2'h0, 16'h0020, 16'h0, 1'b0, 4'h4, 2'h2);
    rc("sat pos", RG_Y1, 16'h7FFF);
  endtask

  task automatic t_status;
    im(RG_X0, 16'h81FF);
    mv(RG_X0, RG_SR);
    chk("sr load", 36'(status_word_q), 36'(16'h81FF & SR_MASK));
    im(RG_X0, 16'h0300);
    mv(RG_X0, RG_SR);
    chk("sr clear", 36'(status_word_q), 36'h0300);
  endtask

  // no stack-to-stack move is ever issued
  task automatic t_stack;
    im(RG_X0, 16'h1111);
    mv(RG_X0, RG_HWS);
    chk("push1", 36'({status_word_q[15], nested_loop_q}), 36'h2);
    im(RG_X0, 16'h2222);
    mv(RG_X0, RG_HWS);
    chk("push2", 36'({status_word_q[15], nested_loop_q}), 36'h3);
    mv(RG_HWS, RG_Y0);
    rc("pop1", RG_Y0, 16'h2222);
    chk("pop1 fl", 36'({status_word_q[15], nested_loop_q}), 36'h2);
    mv(RG_HWS, RG_Y1);
    rc("pop2", RG_Y1, 16'h1111);
    chk("pop2 fl", 36'({status_word_q[15], nested_loop_q}), 36'h0);
  endtask

  task automatic t_timing;
    logic [2:0] md[4];
    logic [3:0] cy[4];
    logic [1:0] wd[4];
    md = '{MODE_IND, MODE_ABS, MODE_IDXN, MODE_DISP};
    cy = '{4'h2, 4'h4, 4'h4, 4'h6};
    wd = '{2'h1, 2'h2, 2'h1, 2'h2};
    for (int j = 0; j < 4; j++) begin
      op(KIND_CTRL, RG_X0, RG_MEM, md[j], 2'h0, 16'h0030, 16'h0, 1'b0, cy[j], wd[j]);
      op(KIND_CTRL, RG_MEM, RG_Y0, md[j], 2'h0, 16'h0030, 16'h0, 1'b0, cy[j], wd[j]);
    end
  endtask

  // no push, pop, loop or return follows
  task automatic t_ptr;
    mw(16'h0000, 16'hBBBB);
    mw(16'h0010, 16'hAAAA);
    im(RG_R1, 16'h0010);
    op(KIND_CTRL, RG_MEM, RG_Y0, MODE_IND, 2'h1, 16'h0, 16'h0, 1'b0, 4'h2, 2'h1);
    op(KIND_CTRL, RG_MEM, RG_Y1, MODE_IND, 2'h1, 16'h0, 16'h0, 1'b0, 4'h2, 2'h1);
    rc("r1 late", RG_Y0, 16'hBBBB);
    rc("r1 new", RG_Y1, 16'hAAAA);
    im(RG_X0, 16'h0777);
    mv(RG_X0, RG_SP);
    chk("sp old", 36'(sp_ptr_q), 36'h0);
    mv(RG_X0, RG_Y0);
    chk("sp new", 36'(sp_ptr_q), 36'h0777);
    im(RG_X0, 16'h0010);
    op(KIND_CTRL, RG_X0, RG_N, MODE_REG, 2'h0, 16'h0, 16'h0, 1'b1, 4'h4, 2'h1);
    op(KIND_CTRL, RG_MEM, RG_Y0, MODE_IDXN, 2'h0, 16'h0, 16'h0, 1'b0, 4'h4, 2'h1);
    rc("n now", RG_Y0, 16'hAAAA);
    op(KIND_CTRL, RG_X0, RG_N, MODE_REG, 2'h0, 16'h0, 16'h0, 1'b0, 4'h2, 2'h1);
    op(KIND_BITF, 5'h00, RG_N, MODE_REG, 2'h0, 16'h0, 16'h0, 1'b1, 4'h2, 2'h1);
    op(KIND_CTRL, RG_MEM, RG_Y0, MODE_IDXN, 2'h0, 16'h0, 16'h0, 1'b0, 4'h4, 2'h1);
    op(KIND_CTRL, RG_MEM, RG_Y1, MODE_IDXN, 2'h0, 16'h0, 16'h0, 1'b0, 4'h4, 2'h1);
    rc("bf n old", RG_Y0, 16'hAAAA);
    rc("bf n new", RG_Y1, 16'hBBBB);
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // run needs under 1000 cycles; margin for stalls
  initial begin
    #100000;
    failures++;
    close_out;
  end

  initial begin
    failures = 0;
    total_checks = 0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_kind = 2'h0;
    op_src = 5'h00;
    op_dst = 5'h00;
    op_mode = 3'h0;
    op_ptr = 2'h0;
    op_ext = 16'h0000;
    op_imm = 16'h0000;
    op_next_uses_n = 1'b0;
    rd_sel = 5'h00;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_imm;
    t_acc;
    t_status;
    t_stack;
    t_timing;
    t_ptr;
    close_out;
  end
endmodule
`default_nettype wire
